// ==== hdl/current_limit_relay_protector.v ====
`timescale 1ns/1ps
`include "relay_guard_regs.vh"

module current_limit_relay_protector #(
  parameter TICK_CYC   = `TICK_CYC,
  parameter LONG_TICKS = `LONG_TICKS
) (
  // Clock and reset
  input  wire        CLK_SYS_IN,
  input  wire        RESET_N_IN,
  // Front-panel keys, high while pressed
  input  wire        KEY_SET_IN,
  input  wire        KEY_PLUS_IN,
  input  wire        KEY_MINUS_IN,
  input  wire        KEY_CANCEL_IN,
  // Measured current, 10 mA units, same clock
  input  wire [15:0] CURRENT_IN,
  // Avalon-MM slave
  input  wire [3:0]  AVS_ADDRESS_IN,
  input  wire        AVS_READ_IN,
  input  wire        AVS_WRITE_IN,
  input  wire [31:0] AVS_WRITEDATA_IN,
  output reg  [31:0] AVS_READDATA_OUT,
  output reg         AVS_WAITREQUEST_OUT,
  // Relay and interrupt
  output reg         RELAY_OUT,
  output reg         IRQ_OUT,
  // Display
  output reg  [1:0]  DISP_MODE_OUT,
  output reg  [3:0]  DISP_ITEM_OUT,
  output reg  [15:0] DISP_VALUE_OUT,
  output reg  [1:0]  DISP_CURSOR_OUT,
  output reg         DISP_FLASH_OUT
);

  localparam [1:0] ST_LIVE = 2'h0;
  localparam [1:0] ST_MENU = 2'h1;
  localparam [1:0] ST_EDIT = 2'h2;

  // Acceptance check shared by key saves and bus writes
  function param_ok;
    input [3:0]  item;
    input [15:0] v;
    input [15:0] up;
    input [15:0] lo;
    begin
      case (item)
        `ITEM_UPPER:
          param_ok = (v == 16'h0000) ||
                     ((v >= lo) && (v <= `FULL_RANGE));
        `ITEM_LOWER:
          param_ok = (v == 16'h0000) ||
                     ((up == 16'h0000) ? (v <= `FULL_RANGE)
                                       : (v <= up));
        `ITEM_BLANK, `ITEM_TRIP:
          param_ok = (v <= `TIME_MAX);
        `ITEM_RELEASE:
          param_ok = (v <= `TIME_MAX) || (v == `RELEASE_OFF);
        default:
          param_ok = 1'b0;
      endcase
    end
  endfunction

  function [15:0] pow10;
    input [1:0] d;
    begin
      case (d)
        2'h0:    pow10 = 16'h0001;
        2'h1:    pow10 = 16'h000A;
        2'h2:    pow10 = 16'h0064;
        default: pow10 = 16'h03E8;
      endcase
    end
  endfunction

  // Time base
  reg  [23:0] tick_cnt_q;
  reg         tick_q;

  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tick_cnt_q <= 24'h000000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYC - 1) begin
      tick_cnt_q <= 24'h000000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q     <= 1'b0;
    end
  end

  // Keys: bit 0 set, 1 plus, 2 minus, 3 cancel
  wire [3:0] key_raw = {KEY_CANCEL_IN, KEY_MINUS_IN, KEY_PLUS_IN, KEY_SET_IN};
  wire [3:0] press_w;
  wire [3:0] short_w;
  wire [3:0] long_w;

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : keys
      key_sense #(
        .LONG_TICKS (LONG_TICKS),
        .DEB_TICKS  (`DEBOUNCE_TICKS),
        .REP_TICKS  (`REPEAT_TICKS)
      ) u_key (
        .clk_in    (CLK_SYS_IN),
        .rst_n_in  (RESET_N_IN),
        .tick_in   (tick_q),
        .key_in    (key_raw[k]),
        .press_out (press_w[k]),
        .short_out (short_w[k]),
        .long_out  (long_w[k])
      );
    end
  endgenerate

  // Stored parameters
  reg [15:0] upper_q;
  reg [15:0] lower_q;
  reg [15:0] blank_t_q;
  reg [15:0] trip_t_q;
  reg [15:0] rel_t_q;

  // Menu state
  reg [1:0]  state_q;
  reg [3:0]  item_q;
  reg [15:0] edit_q;
  reg [1:0]  digit_q;

  // Protection state
  reg        blank_q;
  reg [15:0] blank_cnt_q;
  reg [15:0] trip_cnt_q;
  reg [15:0] rel_cnt_q;
  reg        relay_q;

  // Bus and interrupt state
  reg [3:0]  irq_st_q;
  reg [3:0]  irq_mask_q;

  wire bus_req  = AVS_READ_IN | AVS_WRITE_IN;
  wire bus_done = bus_req & ~AVS_WAITREQUEST_OUT;
  wire bus_wr   = bus_done & AVS_WRITE_IN;
  wire bus_rd   = bus_done & AVS_READ_IN;
  wire [15:0] wr_val = AVS_WRITEDATA_IN[15:0];
  wire wr_ok = param_ok(AVS_ADDRESS_IN, wr_val, upper_q, lower_q);

  // Limit evaluation
  wire over  = (upper_q != 16'h0000) && (CURRENT_IN > upper_q);
  wire under = (lower_q != 16'h0000) && (CURRENT_IN < lower_q);
  wire viol  = over | under;
  wire fault = viol & ~blank_q;
  wire latch_mode = (rel_t_q == `RELEASE_OFF);

  reg [15:0] item_val;
  always @* begin
    case (item_q)
      `ITEM_UPPER:   item_val = upper_q;
      `ITEM_LOWER:   item_val = lower_q;
      `ITEM_BLANK:   item_val = blank_t_q;
      `ITEM_TRIP:    item_val = trip_t_q;
      `ITEM_RELEASE: item_val = rel_t_q;
      default:       item_val = 16'h0000;
    endcase
  end

  // Edit value stepping
  wire [15:0] step   = pow10(digit_q);
  wire [15:0] maxv   = (item_q <= `ITEM_LOWER) ? `FULL_RANGE : `TIME_MAX;
  wire [16:0] sum    = {1'b0, edit_q} + {1'b0, step};
  reg  [15:0] edit_up;
  reg  [15:0] edit_dn;
  always @* begin
    if (edit_q == `RELEASE_OFF)
      edit_up = `RELEASE_OFF;
    else if (sum > {1'b0, maxv})
      // Past the top only the release item at the top digit reaches off
      edit_up = (item_q == `ITEM_RELEASE && digit_q == 2'h3) ?
                `RELEASE_OFF : maxv;
    else
      edit_up = sum[15:0];
    if (edit_q == `RELEASE_OFF)
      edit_dn = `TIME_MAX;
    else if (edit_q < step)
      edit_dn = 16'h0000;
    else
      edit_dn = edit_q - step;
  end

  wire save_key = (state_q == ST_EDIT) && long_w[0];
  wire save_ok  = save_key && param_ok(item_q, edit_q, upper_q, lower_q);
  wire restore  = long_w[3] && (state_q == ST_LIVE) && latch_mode &&
                  relay_q && !viol;

  // Menu machine
  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= ST_LIVE;
      item_q  <= 4'h0;
      edit_q  <= 16'h0000;
      digit_q <= 2'h0;
    end else begin
      case (state_q)
        ST_LIVE: begin
          if (long_w[0]) begin
            state_q <= ST_MENU;
            item_q  <= `ITEM_UPPER;
          end
        end
        ST_MENU: begin
          if (press_w[1])
            item_q <= (item_q == `ITEM_LAST) ? 4'h0
                                             : item_q + 4'h1;
          else if (press_w[2])
            item_q <= (item_q == 4'h0) ? `ITEM_LAST
                                       : item_q - 4'h1;
          else if (short_w[0] && item_q <= `ITEM_RELEASE) begin
            state_q <= ST_EDIT;
            edit_q  <= item_val;
            digit_q <= 2'h0;
          end else if (short_w[3] || long_w[0])
            state_q <= ST_LIVE;
        end
        ST_EDIT: begin
          if (save_key)
            state_q <= ST_LIVE;
          else if (short_w[3])
            state_q <= ST_MENU;
          else if (short_w[0])
            digit_q <= digit_q + 2'h1;
          else if (press_w[1])
            edit_q <= edit_up;
          else if (press_w[2])
            edit_q <= edit_dn;
        end
        default: state_q <= ST_LIVE;
      endcase
    end
  end

  // Parameter storage from keys or bus
  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      upper_q   <= `RST_UPPER;
      lower_q   <= `RST_LOWER;
      blank_t_q <= `RST_BLANK;
      trip_t_q  <= `RST_TRIP;
      rel_t_q   <= `RST_RELEASE;
    end else if (save_ok) begin
      case (item_q)
        `ITEM_UPPER:   upper_q   <= edit_q;
        `ITEM_LOWER:   lower_q   <= edit_q;
        `ITEM_BLANK:   blank_t_q <= edit_q;
        `ITEM_TRIP:    trip_t_q  <= edit_q;
        `ITEM_RELEASE: rel_t_q   <= edit_q;
        default:       upper_q   <= upper_q;
      endcase
    end else if (bus_wr && wr_ok) begin
      case (AVS_ADDRESS_IN)
        `REG_UPPER:   upper_q   <= wr_val;
        `REG_LOWER:   lower_q   <= wr_val;
        `REG_BLANK:   blank_t_q <= wr_val;
        `REG_TRIP:    trip_t_q  <= wr_val;
        `REG_RELEASE: rel_t_q   <= wr_val;
        default:      upper_q   <= upper_q;
      endcase
    end
  end

  // Protection timers and relay
  wire blank_end = blank_q && ((blank_t_q == 16'h0000) ||
                   (blank_cnt_q >= blank_t_q));
  wire trip_now  = !relay_q && fault && ((trip_t_q == 16'h0000) ||
                   (trip_cnt_q >= trip_t_q));
  wire rel_now   = relay_q && !viol && !latch_mode &&
                   ((rel_t_q == 16'h0000) ||
                    (rel_cnt_q >= rel_t_q));

  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      blank_q     <= 1'b1;
      blank_cnt_q <= 16'h0000;
      trip_cnt_q  <= 16'h0000;
      rel_cnt_q   <= 16'h0000;
      relay_q     <= 1'b0;
    end else begin
      if (blank_end)
        blank_q <= 1'b0;
      else if (blank_q && tick_q)
        blank_cnt_q <= blank_cnt_q + 16'h0001;
      // Counters restart whenever their condition drops
      if (!fault || relay_q)
        trip_cnt_q <= 16'h0000;
      else if (tick_q && trip_cnt_q != 16'hFFFF)
        trip_cnt_q <= trip_cnt_q + 16'h0001;
      if (!relay_q || viol)
        rel_cnt_q <= 16'h0000;
      else if (tick_q && rel_cnt_q != 16'hFFFF)
        rel_cnt_q <= rel_cnt_q + 16'h0001;
      if (trip_now)
        relay_q <= 1'b1;
      else if (rel_now || restore)
        relay_q <= 1'b0;
    end
  end

  // Register bus: one wait cycle, then the answer
  wire [3:0] events = {save_ok | (bus_wr & wr_ok), blank_end,
                       rel_now | restore, trip_now};
  wire irq_clr = bus_rd && (AVS_ADDRESS_IN == `REG_IRQ_STATUS);
  wire [3:0] status = {viol, latch_mode, blank_q, relay_q};

  reg [31:0] rd_mux;
  always @* begin
    case (AVS_ADDRESS_IN)
      `REG_UPPER:      rd_mux = {16'h0000, upper_q};
      `REG_LOWER:      rd_mux = {16'h0000, lower_q};
      `REG_BLANK:      rd_mux = {16'h0000, blank_t_q};
      `REG_TRIP:       rd_mux = {16'h0000, trip_t_q};
      `REG_RELEASE:    rd_mux = {16'h0000, rel_t_q};
      `REG_CURRENT:    rd_mux = {16'h0000, CURRENT_IN};
      `REG_STATUS:     rd_mux = {28'h0000000, status};
      `REG_IRQ_STATUS: rd_mux = {28'h0000000, irq_st_q};
      `REG_IRQ_MASK:   rd_mux = {28'h0000000, irq_mask_q};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h00000000;
      irq_st_q            <= 4'h0;
      irq_mask_q          <= 4'h0;
      IRQ_OUT             <= 1'b0;
    end else begin
      AVS_WAITREQUEST_OUT <= ~(bus_req & AVS_WAITREQUEST_OUT);
      if (bus_req && AVS_WAITREQUEST_OUT && AVS_READ_IN)
        AVS_READDATA_OUT <= rd_mux;
      if (bus_wr && AVS_ADDRESS_IN == `REG_IRQ_MASK)
        irq_mask_q <= AVS_WRITEDATA_IN[3:0];
      // A new event wins over the read that clears
      irq_st_q <= (irq_st_q & {4{~irq_clr}}) | events;
      IRQ_OUT  <= |(irq_st_q & irq_mask_q);
    end
  end

  // Display and relay outputs
  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      RELAY_OUT       <= 1'b0;
      DISP_MODE_OUT   <= ST_LIVE;
      DISP_ITEM_OUT   <= 4'h0;
      DISP_VALUE_OUT  <= 16'h0000;
      DISP_CURSOR_OUT <= 2'h0;
      DISP_FLASH_OUT  <= 1'b0;
    end else begin
      RELAY_OUT       <= relay_q;
      DISP_MODE_OUT   <= state_q;
      DISP_ITEM_OUT   <= item_q;
      DISP_CURSOR_OUT <= digit_q;
      DISP_FLASH_OUT  <= (state_q == ST_EDIT);
      case (state_q)
        ST_LIVE: DISP_VALUE_OUT <= CURRENT_IN;
        ST_EDIT: DISP_VALUE_OUT <= edit_q;
        default: DISP_VALUE_OUT <= item_val;
      endcase
    end
  end

endmodule

// ==== hdl/key_sense.v ====
`timescale 1ns/1ps
`include "relay_guard_regs.vh"

module key_sense #(
  parameter LONG_TICKS = `LONG_TICKS,
  parameter DEB_TICKS  = `DEBOUNCE_TICKS,
  parameter REP_TICKS  = `REPEAT_TICKS
) (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire tick_in,
  // Raw key, high while pressed
  input  wire key_in,
  // Classified events, one-cycle pulses
  output reg  press_out,
  output reg  short_out,
  output reg  long_out
);

  reg        s1_q;
  reg        s2_q;
  reg        stable_q;
  reg        long_seen_q;
  reg [3:0]  deb_q;
  reg [11:0] hold_q;
  reg [7:0]  rep_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q        <= 1'b0;
      s2_q        <= 1'b0;
      stable_q    <= 1'b0;
      long_seen_q <= 1'b0;
      deb_q       <= 4'h0;
      hold_q      <= 12'h000;
      rep_q       <= 8'h00;
      press_out   <= 1'b0;
      short_out   <= 1'b0;
      long_out    <= 1'b0;
    end else begin
      s1_q      <= key_in;
      s2_q      <= s1_q;
      press_out <= 1'b0;
      short_out <= 1'b0;
      long_out  <= 1'b0;
      if (s2_q != stable_q) begin
        if (tick_in) begin
          if (deb_q == DEB_TICKS - 1) begin
            deb_q    <= 4'h0;
            stable_q <= s2_q;
            if (s2_q) begin
              press_out   <= 1'b1;
              hold_q      <= 12'h000;
              rep_q       <= 8'h00;
              long_seen_q <= 1'b0;
            end else if (long_seen_q) begin
              long_out <= 1'b1;
            end else begin
              short_out <= 1'b1;
            end
          end else begin
            deb_q <= deb_q + 4'h1;
          end
        end
      end else begin
        deb_q <= 4'h0;
        if (stable_q && tick_in) begin
          if (hold_q == LONG_TICKS - 1)
            long_seen_q <= 1'b1;
          if (!long_seen_q)
            hold_q <= hold_q + 12'h001;
          // Held keys repeat so a value can be run up quickly
          if (rep_q == REP_TICKS - 1) begin
            rep_q     <= 8'h00;
            press_out <= 1'b1;
          end else begin
            rep_q <= rep_q + 8'h01;
          end
        end
      end
    end
  end

endmodule

// ==== pkg/relay_guard_regs.vh ====
`ifndef RELAY_GUARD_REGS_VH
`define RELAY_GUARD_REGS_VH

// Timing
`define CLK_PERIOD_NS   10
`define TICK_NS         10000000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define LONG_MS         3000
`define LONG_TICKS      (`LONG_MS / 10)
`define DEBOUNCE_TICKS  2
`define REPEAT_TICKS    20

// Value ranges: currents in 10 mA units, times in 10 ms ticks
`define FULL_RANGE      16'h01F4
`define TIME_MAX        16'h2706
`define RELEASE_OFF     16'hFFFF

// Menu items
`define ITEM_UPPER      4'h0
`define ITEM_LOWER      4'h1
`define ITEM_BLANK      4'h2
`define ITEM_TRIP       4'h3
`define ITEM_RELEASE    4'h4
`define ITEM_LAST       4'h8

// Register word addresses
`define REG_UPPER       4'h0
`define REG_LOWER       4'h1
`define REG_BLANK       4'h2
`define REG_TRIP        4'h3
`define REG_RELEASE     4'h4
`define REG_CURRENT     4'h5
`define REG_STATUS      4'h6
`define REG_IRQ_STATUS  4'h7
`define REG_IRQ_MASK    4'h8

// Status bits
`define ST_RELAY        0
`define ST_BLANK        1
`define ST_LATCHED      2
`define ST_VIOLATION    3

// Event bits
`define EV_TRIP         0
`define EV_RELEASE      1
`define EV_BLANK_DONE   2
`define EV_SAVED        3

// Reset values of the parameters
`define RST_UPPER       16'h0000
`define RST_LOWER       16'h0000
`define RST_BLANK       16'h0064
`define RST_TRIP        16'h0064
`define RST_RELEASE     16'h0064

`endif

// ==== test/panel_model.sv ====
`timescale 1ns/1ps
module panel_model #(
  parameter GAP = 40
) (
  input  wire         clk_in,
  output logic [3:0]  key_out,
  output logic [15:0] current_out
);
  initial begin
    key_out     = 4'h0;
    current_out = 16'h0064;
  end
  task automatic key_down(input int k);
    @(posedge clk_in);
    key_out[k] <= 1'b1;
  endtask
  // Idle after release long enough for the release to be debounced
  task automatic key_up(input int k);
    @(posedge clk_in);
    key_out[k] <= 1'b0;
    repeat (GAP) @(posedge clk_in);
  endtask
  task automatic press(input int k, input int hold);
    key_down(k);
    repeat (hold) @(posedge clk_in);
    key_up(k);
  endtask
  task automatic set_current(input logic [15:0] v);
    @(posedge clk_in);
    current_out <= v;
  endtask
endmodule

// ==== test/relay_guard_props.sv ====
`timescale 1ns/1ps
module relay_guard_props (
  input wire        CLK_SYS_IN,
  input wire        RESET_N_IN,
  input wire        AVS_READ_IN,
  input wire        AVS_WRITE_IN,
  input wire [31:0] AVS_READDATA_OUT,
  input wire        AVS_WAITREQUEST_OUT,
  input wire [1:0]  DISP_MODE_OUT,
  input wire [3:0]  DISP_ITEM_OUT,
  input wire [1:0]  DISP_CURSOR_OUT,
  input wire        DISP_FLASH_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  reg  [1:0] mode_q;
  reg  [3:0] item_q;
  reg  [1:0] cur_q;
  wire       req     = AVS_READ_IN | AVS_WRITE_IN;
  wire [3:0] item_nx = (item_q == 4'h8) ? 4'h0 : item_q + 4'h1;
  wire [3:0] item_pv = (item_q == 4'h0) ? 4'h8 : item_q - 4'h1;
  always @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode_q <= 2'h0;
      item_q <= 4'h0;
      cur_q  <= 2'h0;
    end else begin
      mode_q <= DISP_MODE_OUT;
      item_q <= DISP_ITEM_OUT;
      cur_q  <= DISP_CURSOR_OUT;
    end
  end
  a_bus_one_wait: assert property (req && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT) else $error("waitrequest not low after one");
  a_bus_wait_pulse: assert property ($fell(AVS_WAITREQUEST_OUT)
    |=> $rose(AVS_WAITREQUEST_OUT)) else $error("waitrequest low too long");
  a_bus_idle_wait: assert property (!req && AVS_WAITREQUEST_OUT
    |=> AVS_WAITREQUEST_OUT) else $error("completion without request");
  a_bus_upper_zero: assert property (!AVS_WAITREQUEST_OUT && AVS_READ_IN
    |-> AVS_READDATA_OUT[31:16] == 16'h0000) else $error("upper data set");
  a_item_range: assert property (DISP_ITEM_OUT <= 4'h8)
    else $error("menu item out of range");
  a_menu_entry: assert property (DISP_MODE_OUT == 2'h1 && mode_q == 2'h0
    |-> DISP_ITEM_OUT == 4'h0) else $error("menu not opened at first item");
  a_menu_step: assert property (DISP_MODE_OUT == 2'h1 && mode_q == 2'h1
    && DISP_ITEM_OUT != item_q |-> DISP_ITEM_OUT == item_nx
    || DISP_ITEM_OUT == item_pv) else $error("menu item jumped");
  a_flash_edit: assert property (DISP_FLASH_OUT == (DISP_MODE_OUT == 2'h2))
    else $error("flash does not follow edit");
  a_edit_entry: assert property (DISP_MODE_OUT == 2'h2 && mode_q != 2'h2
    |-> mode_q == 2'h1 && DISP_CURSOR_OUT == 2'h0) else $error("bad edit entry");
  a_cursor_step: assert property (DISP_MODE_OUT == 2'h2 && mode_q == 2'h2
    && DISP_CURSOR_OUT != cur_q |-> DISP_CURSOR_OUT == cur_q + 2'h1)
    else $error("cursor did not step by one");
endmodule
bind current_limit_relay_protector relay_guard_props u_props (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .DISP_MODE_OUT(DISP_MODE_OUT), .DISP_ITEM_OUT(DISP_ITEM_OUT),
  .DISP_CURSOR_OUT(DISP_CURSOR_OUT), .DISP_FLASH_OUT(DISP_FLASH_OUT));

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "relay_guard_regs.vh"
module tb_top;
  typedef struct packed {
    logic        w;
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;
  localparam SET = 0, PLUS = 1, MINUS = 2, CAN = 3, SH = 40, LG = 100;
  logic        clk, rst_n, avs_rd, avs_wr;
  logic [3:0]  avs_addr;
  logic [31:0] avs_wdata, q;
  logic [3:0]  key;
  logic [15:0] cur;
  wire  [31:0] AVS_READDATA_OUT;
  wire         AVS_WAITREQUEST_OUT, RELAY_OUT, IRQ_OUT, DISP_FLASH_OUT;
  wire  [1:0]  DISP_MODE_OUT, DISP_CURSOR_OUT;
  wire  [3:0]  DISP_ITEM_OUT;
  wire  [15:0] DISP_VALUE_OUT;
  int          fail_count, n_tests, n, i;
  row_t        rows [17];
  panel_model pm (.clk_in(clk), .key_out(key), .current_out(cur));
  current_limit_relay_protector #(.TICK_CYC(10), .LONG_TICKS(5)) dut (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
    .KEY_SET_IN(key[0]), .KEY_PLUS_IN(key[1]),
    .KEY_MINUS_IN(key[2]), .KEY_CANCEL_IN(key[3]), .CURRENT_IN(cur),
    .AVS_ADDRESS_IN(avs_addr), .AVS_READ_IN(avs_rd), .AVS_WRITE_IN(avs_wr),
    .AVS_WRITEDATA_IN(avs_wdata), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .RELAY_OUT(RELAY_OUT),
    .IRQ_OUT(IRQ_OUT), .DISP_MODE_OUT(DISP_MODE_OUT),
    .DISP_ITEM_OUT(DISP_ITEM_OUT), .DISP_VALUE_OUT(DISP_VALUE_OUT),
    .DISP_CURSOR_OUT(DISP_CURSOR_OUT), .DISP_FLASH_OUT(DISP_FLASH_OUT));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("%0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low, giving up after 50 cycles
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] d);
    int k;
    @(posedge clk);
    avs_addr  <= a;
    avs_wdata <= {16'h0000, d};
    if (w) avs_wr <= 1'b1;
    else avs_rd <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (AVS_WAITREQUEST_OUT !== 1'b0 && k < 50);
    q = AVS_READDATA_OUT;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (k >= 50) fail_count++;
  endtask
  task automatic wait_relay(input logic v, input int lim);
    n = 0;
    while (RELAY_OUT !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic done(input string s);
    $display("end of %s", s);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    finish_test;
  end
  initial begin
    rst_n = 1'b0; avs_rd = 1'b0; avs_wr = 1'b0;
    avs_addr = 4'h0; avs_wdata = 32'h0;
    fail_count = 0; n_tests = 0;
    rows = '{'{1'b0, 4'h0, 16'h0000, 16'h0000},
      '{1'b0, 4'h1, 16'h0000, 16'h0000}, '{1'b0, 4'h2, 16'h0000, `RST_BLANK},
      '{1'b0, 4'h3, 16'h0000, `RST_TRIP}, '{1'b0, 4'h4, 16'h0000, `RST_RELEASE},
      '{1'b0, 4'h8, 16'h0000, 16'h0000}, '{1'b0, 4'h9, 16'h0000, 16'h0000},
      '{1'b1, 4'h0, 16'h00C8, 16'h00C8}, '{1'b1, 4'h1, 16'h012C, 16'h0000},
      '{1'b1, 4'h1, 16'h0032, 16'h0032}, '{1'b1, 4'h0, 16'h0028, 16'h00C8},
      '{1'b1, 4'h0, 16'h01F5, 16'h00C8}, '{1'b1, 4'h3, 16'h0003, 16'h0003},
      '{1'b1, 4'h4, 16'h0002, 16'h0002}, '{1'b1, 4'h5, 16'h1234, 16'h0064},
      '{1'b1, 4'h9, 16'hABCD, 16'h0000}, '{1'b1, 4'h8, 16'h000F, 16'h000F}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 17; i++) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 16'h0000);
      check(q, {16'h0000, rows[i].e});
    end
    done("register rows");
    // Over-current while blanking must not trip
    pm.set_current(16'h012C);
    wait_relay(1'b1, 800);
    check(RELAY_OUT, 1'b0);
    wait_relay(1'b1, 400);
    check(RELAY_OUT, 1'b1);
    check(IRQ_OUT, 1'b1);
    bus(1'b0, 4'h7, 16'h0000);
    check(q & 32'h7, 32'h5);
    bus(1'b0, 4'h7, 16'h0000);
    check(q & 32'h7, 32'h0);
    check(IRQ_OUT, 1'b0);
    pm.set_current(16'h0064);
    repeat (8) @(posedge clk);
    check(RELAY_OUT, 1'b1);
    wait_relay(1'b0, 60);
    check(RELAY_OUT, 1'b0);
    done("blank and trip");
    pm.set_current(16'h012C);
    repeat (15) @(posedge clk);
    pm.set_current(16'h0064);
    wait_relay(1'b1, 60);
    check(RELAY_OUT, 1'b0);
    pm.set_current(16'h012C);
    wait_relay(1'b1, 100);
    check(n >= 20 && n <= 40, 1'b1);
    pm.set_current(16'h0064);
    wait_relay(1'b0, 60);
    check(RELAY_OUT, 1'b0);
    // Start released so that the under-current trip itself is seen
    pm.set_current(16'h0014);
    wait_relay(1'b1, 100);
    check(RELAY_OUT, 1'b1);
    pm.set_current(16'h0064);
    wait_relay(1'b0, 60);
    bus(1'b1, 4'h1, 16'h0000);
    pm.set_current(16'h0000);
    wait_relay(1'b1, 100);
    check(RELAY_OUT, 1'b0);
    pm.set_current(16'h0064);
    done("delays and limits");
    pm.press(SET, SH);
    check(DISP_MODE_OUT, 2'h0);
    pm.key_down(SET);
    repeat (LG) @(posedge clk);
    check(DISP_MODE_OUT, 2'h0);
    pm.key_up(SET);
    check({DISP_MODE_OUT, DISP_ITEM_OUT, DISP_VALUE_OUT}, 22'h1000C8);
    pm.press(PLUS, SH);
    check({DISP_ITEM_OUT, DISP_VALUE_OUT}, 20'h10000);
    pm.press(MINUS, SH);
    pm.press(MINUS, SH);
    check(DISP_ITEM_OUT, 4'h8);
    pm.press(PLUS, SH);
    pm.press(SET, SH);
    check({DISP_MODE_OUT, DISP_FLASH_OUT, DISP_VALUE_OUT}, 19'h500C8);
    pm.press(PLUS, SH);
    check(DISP_VALUE_OUT, 16'h00C9);
    pm.press(CAN, SH);
    check(DISP_MODE_OUT, 2'h1);
    bus(1'b0, 4'h0, 16'h0000);
    check(q, 32'hC8);
    bus(1'b1, 4'h8, 16'h0000);
    pm.press(SET, SH);
    pm.press(SET, SH);
    check(DISP_CURSOR_OUT, 2'h1);
    pm.press(PLUS, SH);
    pm.press(SET, LG);
    check(DISP_MODE_OUT, 2'h0);
    bus(1'b0, 4'h0, 16'h0000);
    check(q, 32'hD2);
    check(IRQ_OUT, 1'b0);
    bus(1'b1, 4'h8, 16'h0008);
    repeat (3) @(posedge clk);
    check(IRQ_OUT, 1'b1);
    bus(1'b0, 4'h7, 16'h0000);
    repeat (3) @(posedge clk);
    check(IRQ_OUT, 1'b0);
    done("menu editing");
    pm.press(SET, LG);
    repeat (4) pm.press(PLUS, SH);
    pm.press(SET, SH);
    repeat (3) pm.press(SET, SH);
    check({DISP_ITEM_OUT, DISP_CURSOR_OUT}, 6'h13);
    // Auto-repeat advances a thousand per step, so OFF needs ten steps
    pm.key_down(PLUS);
    for (n = 0; n < 3000 && DISP_VALUE_OUT !== `RELEASE_OFF; n++)
      @(posedge clk);
    pm.key_up(PLUS);
    check(DISP_VALUE_OUT, `RELEASE_OFF);
    pm.press(SET, LG);
    bus(1'b0, 4'h4, 16'h0000);
    check(q, {16'h0000, `RELEASE_OFF});
    pm.set_current(16'h012C);
    wait_relay(1'b1, 100);
    pm.set_current(16'h0064);
    repeat (200) @(posedge clk);
    check(RELAY_OUT, 1'b1);
    pm.press(CAN, LG);
    wait_relay(1'b0, 60);
    check(RELAY_OUT, 1'b0);
    done("latch and manual restore");
    finish_test;
  end
endmodule
